// file: logic/hps_param_store.sv
// Behaviour
// - Working values are lost at power loss unless saved first.
// - Entries with protected descriptor refuse every write.
// - Time, date and counter entries write through to retentive store at once.
// - Save service copies all working values into retentive store.
// - Restore service reloads all working values from retentive store, any time.
// - Reset service loads defaults into working and retentive store.
// - Services only address class entry 0 and act on all entries.
// - At power-up working values load from retentive store, or defaults fill both when it is blank.
// - Identity type 1 reset also restores all defaults.
// - Selector picks 300, 500, PC, rotary switch, or entries 11 and 10.
// - Calibration 0 to 40, default 20; -1 takes set-point input.
// - Heating ends after time limit; no reheat until start drops.
// - Time limit in 10 ms units, 0 to 999, default 500.
// - Measuring impulses have configured length, default 1.7 ms.
// - One byte order setting swaps both cyclic in and out words.
// - Start hotter than max start temperature: no heat, error 305, alarm.
// - Diagnosis arms in band at start; leaving band gives 307/308.
// - Not armed when start drops gives 309/310 and alarm.
// - Band limits shared with window flag, default 10 K each side.
// - Delay after first low-limit crossing holds off arming.
module hps_param_store #(
	parameter int TICK_CYC      = hps_pkg::TICK_CYC,
	parameter int MEAS_UNIT_CYC = hps_pkg::MEAS_UNIT_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        nv_blank,
	input  wire logic        heat_start_bit,
	input  wire logic [15:0] actual_temp,
	input  wire logic [15:0] set_point,
	input  wire logic [9:0]  rotary_range,
	input  wire logic [7:0]  rotary_alloy,
	input  wire logic [9:0]  pc_range,
	input  wire logic [7:0]  pc_alloy,
	input  wire logic [15:0] cyc_in_raw,
	input  wire logic [15:0] cyc_out_raw,
	output logic             heat_enable,
	output logic             measure_pulse,
	output logic             alarm,
	output logic [9:0]       error_code,
	output logic             temp_in_window_flag,
	output logic [9:0]       range_celsius,
	output logic [7:0]       alloy_code,
	output logic [15:0]      cal_temp,
	output logic [15:0]      cyc_in_word,
	output logic [15:0]      cyc_out_word
);
	localparam int TW = $clog2(TICK_CYC + 1);

	typedef enum logic [1:0] {EN_IDLE, EN_LOAD, EN_SAVE, EN_DEF} hps_eng_type;
	typedef enum logic [1:0] {SU_IDLE, SU_HEAT, SU_LOCK} hps_sup_type;

	function automatic logic [15:0] dflt(input logic [5:0] i);
		unique case (i)
			hps_pkg::E_SELECT:   dflt = hps_pkg::DEF_SELECT;
			hps_pkg::E_OK_LOW:   dflt = hps_pkg::DEF_OK_LOW;
			hps_pkg::E_OK_HIGH:  dflt = hps_pkg::DEF_OK_HIGH;
			hps_pkg::E_CAL:      dflt = hps_pkg::DEF_CAL;
			hps_pkg::E_LIMIT:    dflt = hps_pkg::DEF_LIMIT;
			hps_pkg::E_MEAS:     dflt = hps_pkg::DEF_MEAS;
			hps_pkg::E_MAXSTART: dflt = hps_pkg::DEF_MAXSTART;
			default:             dflt = 16'h0000;
		endcase
	endfunction : dflt

	function automatic logic is_prot(input logic [5:0] i);
		is_prot = i >= hps_pkg::E_PROT_FIRST && i <= hps_pkg::E_PROT_LAST;
	endfunction : is_prot

	function automatic logic is_pers(input logic [5:0] i);
		is_pers = i == hps_pkg::E_TIME || i == hps_pkg::E_DATE ||
			(i >= hps_pkg::E_CNT_FIRST && i <= hps_pkg::E_CNT_LAST);
	endfunction : is_pers

	function automatic logic val_ok(input logic [5:0] i, input logic [15:0] v);
		unique case (i)
			hps_pkg::E_CAL:      val_ok = v <= hps_pkg::CAL_MAX || v == hps_pkg::CAL_FROM_IN;
			hps_pkg::E_LIMIT,
			hps_pkg::E_DIAG_DLY: val_ok = v <= hps_pkg::TIME_MAX;
			default:             val_ok = 1'b1;
		endcase
	endfunction : val_ok

	// Retentive array has no reset: it stands in for the non-volatile store
	logic [15:0] work_mem [hps_pkg::NUM_ENTRY];
	logic [15:0] ret_mem  [hps_pkg::NUM_ENTRY];

	hps_eng_type eng_q, eng_d;
	hps_sup_type sup_q, sup_d;
	logic [5:0]  idx_q, idx_d, sel_q, sel_d;
	logic        boot_q, boot_d, refused_q, refused_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        w_we, r_we;
	logic [5:0]  w_a, r_a;
	logic [15:0] w_v, r_v, merged;
	logic        wr_go, rd_go, wr_ok;

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign rd_go = s_axi_arvalid && !rvalid_q;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign merged = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : work_mem[sel_q][15:8],
		s_axi_wstrb[0] ? s_axi_wdata[7:0] : work_mem[sel_q][7:0]};

	always_comb begin
		eng_d = eng_q;
		idx_d = idx_q;
		sel_d = sel_q;
		boot_d = 1'b0;
		refused_d = refused_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !s_axi_rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		w_we = 1'b0;
		w_a = idx_q;
		w_v = ret_mem[idx_q];
		r_we = 1'b0;
		r_a = idx_q;
		r_v = work_mem[idx_q];
		wr_ok = 1'b0;
		unique case (eng_q)
			EN_IDLE: begin
				idx_d = '0;
				if (boot_q)
					eng_d = nv_blank ? EN_DEF : EN_LOAD;
			end
			EN_LOAD: w_we = 1'b1;
			EN_SAVE: r_we = 1'b1;
			EN_DEF: begin
				w_we = 1'b1;
				r_we = 1'b1;
				w_v = dflt(idx_q);
				r_v = dflt(idx_q);
			end
		endcase
		if (eng_q != EN_IDLE) begin
			idx_d = idx_q + 6'd1;
			if (idx_q == 6'(hps_pkg::NUM_ENTRY - 1))
				eng_d = EN_IDLE;
		end
		if (wr_go) begin
			bvalid_d = 1'b1;
			unique case (s_axi_awaddr)
				hps_pkg::REG_CMD: begin
					// Whole-store services, class entry only
					if (eng_q == EN_IDLE && !boot_q && s_axi_wdata[15:8] == 8'h00) begin
						wr_ok = 1'b1;
						unique case (s_axi_wdata[7:0])
							hps_pkg::SVC_SAVE:    eng_d = EN_SAVE;
							hps_pkg::SVC_RESTORE: eng_d = EN_LOAD;
							hps_pkg::SVC_RESET:   eng_d = EN_DEF;
							default:              wr_ok = 1'b0;
						endcase
					end
				end
				hps_pkg::REG_IDRST: begin
					wr_ok = eng_q == EN_IDLE && !boot_q &&
						s_axi_wdata[7:0] == hps_pkg::IDRST_TYPE1;
					if (wr_ok)
						eng_d = EN_DEF;
				end
				hps_pkg::REG_SEL: begin
					wr_ok = 1'b1;
					sel_d = s_axi_wdata[5:0];
				end
				hps_pkg::REG_DATA: begin
					wr_ok = eng_q == EN_IDLE && !boot_q && !is_prot(sel_q) &&
						val_ok(sel_q, merged);
					if (wr_ok) begin
						// Working copy changes; time, date and counter entries also go to the retentive copy
						w_we = 1'b1;
						w_a = sel_q;
						w_v = merged;
						r_we = is_pers(sel_q);
						r_a = sel_q;
						r_v = merged;
					end
				end
				hps_pkg::REG_STAT: wr_ok = 1'b1;
				default: wr_ok = 1'b0;
			endcase
			bresp_d = wr_ok ? hps_pkg::RESP_OKAY : hps_pkg::RESP_SLVERR;
			if (s_axi_awaddr == hps_pkg::REG_STAT && s_axi_wdata[13])
				refused_d = 1'b0;
		end
		if (wr_go && !wr_ok)
			refused_d = 1'b1;
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d = hps_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				hps_pkg::REG_SEL:   rdata_d = {26'h0, sel_q};
				hps_pkg::REG_DATA:  rdata_d = {16'h0, work_mem[sel_q]};
				hps_pkg::REG_STAT:  rdata_d = {hps_pkg::ST_RESERVED'(0), refused_q,
					eng_q != EN_IDLE, heat_enable, alarm, error_code};
				hps_pkg::REG_CMD,
				hps_pkg::REG_IDRST: rdata_d = 32'h0;
				default: begin
					rdata_d = 32'h0;
					rresp_d = hps_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (w_we)
			work_mem[w_a] <= w_v;
		if (r_we)
			ret_mem[r_a] <= r_v;
		if (!aresetn) begin
			eng_q <= EN_IDLE;
			idx_q <= '0;
			sel_q <= '0;
			boot_q <= 1'b1;
			refused_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
			rvalid_q <= 1'b0;
			rresp_q <= 2'b00;
			rdata_q <= 32'h0;
		end else begin
			eng_q <= eng_d;
			idx_q <= idx_d;
			sel_q <= sel_d;
			boot_q <= boot_d;
			refused_q <= refused_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	// Supervision
	logic [17:0] rot_s1, rot_s2;
	logic [TW-1:0] tick_cnt_q, tick_cnt_d;
	logic [15:0] hcnt_q, hcnt_d, dcnt_q, dcnt_d, prev_sel;
	logic [31:0] meas_q, meas_d;
	logic        tick, start_q, rise, fall, in_band, above_lo, below_hi;
	logic        armed_q, armed_d, low_seen_q, low_seen_d, alarm_q, alarm_d;
	logic        heat_q, heat_d, meas_on_q, win_q;
	logic [9:0]  err_q, err_d, rng_q, rng_d;
	logic [7:0]  alloy_q, alloy_d;
	logic [15:0] cal_q, cal_d, cin_q, cout_q;
	logic [16:0] act_lo, set_hi;

	assign prev_sel = work_mem[hps_pkg::E_SELECT];
	assign tick = tick_cnt_q == TW'(TICK_CYC - 1);
	assign rise = heat_start_bit && !start_q;
	assign fall = !heat_start_bit && start_q;
	assign act_lo = {1'b0, actual_temp} + {1'b0, work_mem[hps_pkg::E_OK_LOW]};
	assign set_hi = {1'b0, set_point} + {1'b0, work_mem[hps_pkg::E_OK_HIGH]};
	assign above_lo = act_lo >= {1'b0, set_point};
	assign below_hi = {1'b0, actual_temp} <= set_hi;
	assign in_band = above_lo && below_hi;

	always_comb begin
		tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
		sup_d = sup_q;
		hcnt_d = hcnt_q;
		dcnt_d = dcnt_q;
		armed_d = armed_q;
		low_seen_d = low_seen_q;
		alarm_d = alarm_q;
		err_d = err_q;
		heat_d = 1'b0;
		meas_d = meas_q != 32'h0 ? meas_q - 32'h1 : 32'h0;
		unique case (sup_q)
			SU_IDLE: if (rise) begin
				if (actual_temp > work_mem[hps_pkg::E_MAXSTART]) begin
					sup_d = SU_LOCK;
					if (err_q == 10'd0)
						err_d = hps_pkg::ERR_HOT;
					alarm_d = 1'b1;
				end else begin
					sup_d = SU_HEAT;
					heat_d = 1'b1;
					err_d = 10'd0;
					alarm_d = 1'b0;
					hcnt_d = '0;
					dcnt_d = '0;
					armed_d = 1'b0;
					low_seen_d = 1'b0;
				end
			end
			SU_HEAT: begin
				heat_d = 1'b1;
				if (tick)
					hcnt_d = hcnt_q + 16'd1;
				if (above_lo)
					low_seen_d = 1'b1;
				if (low_seen_q && tick && dcnt_q < work_mem[hps_pkg::E_DIAG_DLY])
					dcnt_d = dcnt_q + 16'd1;
				if (work_mem[hps_pkg::E_DIAG_EN][0]) begin
					if (!armed_q && in_band && low_seen_q &&
						dcnt_q >= work_mem[hps_pkg::E_DIAG_DLY])
						armed_d = 1'b1;
					if (armed_q && !in_band && err_q == 10'd0) begin
						err_d = above_lo ? hps_pkg::ERR_LEFT_HI : hps_pkg::ERR_LEFT_LO;
						alarm_d = 1'b1;
					end
				end
				if (!heat_start_bit) begin
					sup_d = SU_IDLE;
					heat_d = 1'b0;
					if (work_mem[hps_pkg::E_DIAG_EN][0] && !armed_q && err_q == 10'd0) begin
						err_d = above_lo ? hps_pkg::ERR_NOARM_HI : hps_pkg::ERR_NOARM_LO;
						alarm_d = 1'b1;
					end
				end else if (work_mem[hps_pkg::E_LIMIT] != 16'h0 &&
					hcnt_q >= work_mem[hps_pkg::E_LIMIT]) begin
					sup_d = SU_LOCK;
					heat_d = 1'b0;
				end
			end
			SU_LOCK: if (!heat_start_bit)
				sup_d = SU_IDLE;
		endcase
		// Measuring impulses only start between heating phases
		if (tick && sup_q != SU_HEAT && meas_q == 32'h0)
			meas_d = 32'(work_mem[hps_pkg::E_MEAS]) * 32'(MEAS_UNIT_CYC);
		unique case (prev_sel[7:0])
			hps_pkg::SEL_300: rng_d = hps_pkg::RANGE_300;
			hps_pkg::SEL_500: rng_d = hps_pkg::RANGE_500;
			hps_pkg::SEL_PC:  rng_d = pc_range;
			hps_pkg::SEL_VAR: rng_d = work_mem[hps_pkg::E_RANGE][9:0];
			default:          rng_d = rot_s2[17:8];
		endcase
		unique case (prev_sel[7:0])
			hps_pkg::SEL_300,
			hps_pkg::SEL_500: alloy_d = 8'h00;
			hps_pkg::SEL_PC:  alloy_d = pc_alloy;
			hps_pkg::SEL_VAR: alloy_d = work_mem[hps_pkg::E_ALLOY][7:0];
			default:          alloy_d = rot_s2[7:0];
		endcase
		cal_d = work_mem[hps_pkg::E_CAL] == hps_pkg::CAL_FROM_IN ? set_point :
			work_mem[hps_pkg::E_CAL];
	end

	always_ff @(posedge aclk) begin
		rot_s1 <= {rotary_range, rotary_alloy};
		rot_s2 <= rot_s1;
		if (!aresetn) begin
			sup_q <= SU_IDLE;
			tick_cnt_q <= '0;
			hcnt_q <= '0;
			dcnt_q <= '0;
			armed_q <= 1'b0;
			low_seen_q <= 1'b0;
			alarm_q <= 1'b0;
			err_q <= '0;
			heat_q <= 1'b0;
			meas_q <= '0;
			meas_on_q <= 1'b0;
			start_q <= 1'b0;
			win_q <= 1'b0;
			rng_q <= '0;
			alloy_q <= '0;
			cal_q <= '0;
			cin_q <= '0;
			cout_q <= '0;
		end else begin
			sup_q <= sup_d;
			tick_cnt_q <= tick_cnt_d;
			hcnt_q <= hcnt_d;
			dcnt_q <= dcnt_d;
			armed_q <= armed_d;
			low_seen_q <= low_seen_d;
			alarm_q <= alarm_d;
			err_q <= err_d;
			heat_q <= heat_d;
			meas_q <= meas_d;
			meas_on_q <= meas_d != 32'h0;
			start_q <= heat_start_bit;
			win_q <= in_band;
			rng_q <= rng_d;
			alloy_q <= alloy_d;
			cal_q <= cal_d;
			cin_q <= work_mem[hps_pkg::E_ORDER][0] ? {cyc_in_raw[7:0], cyc_in_raw[15:8]} :
				cyc_in_raw;
			cout_q <= work_mem[hps_pkg::E_ORDER][0] ? {cyc_out_raw[7:0], cyc_out_raw[15:8]} :
				cyc_out_raw;
		end
	end

	assign heat_enable = heat_q;
	assign measure_pulse = meas_on_q;
	assign alarm = alarm_q;
	assign error_code = err_q;
	assign temp_in_window_flag = win_q;
	assign range_celsius = rng_q;
	assign alloy_code = alloy_q;
	assign cal_temp = cal_q;
	assign cyc_in_word = cin_q;
	assign cyc_out_word = cout_q;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_data_wr;
		wr_go && s_axi_awaddr == hps_pkg::REG_DATA && eng_q == EN_IDLE && !boot_q;
	endsequence

	a_protect_refuse: assert property (s_data_wr ##0 is_prot(sel_q) |=>
		bresp_q == hps_pkg::RESP_SLVERR && work_mem[$past(sel_q)] == $past(work_mem[sel_q]))
		else $error("protected entry changed");
	a_persist_write: assert property (s_data_wr ##0 is_pers(sel_q) && !bvalid_q |=>
		ret_mem[$past(sel_q)] == work_mem[$past(sel_q)])
		else $error("persistent entry not retained");
	a_save_copy: assert property (eng_q == EN_SAVE |=>
		ret_mem[$past(idx_q)] == $past(work_mem[idx_q]))
		else $error("save copy wrong");
	a_load_copy: assert property (eng_q == EN_LOAD |=>
		work_mem[$past(idx_q)] == $past(ret_mem[idx_q]))
		else $error("restore copy wrong");
	a_default_fill: assert property (eng_q == EN_DEF |=>
		work_mem[$past(idx_q)] == dflt($past(idx_q)) && ret_mem[$past(idx_q)] == dflt($past(idx_q)))
		else $error("default fill wrong");
	a_class_only: assert property (wr_go && s_axi_awaddr == hps_pkg::REG_CMD &&
		s_axi_wdata[15:8] != 8'h00 && eng_q == EN_IDLE && !boot_q |=>
		eng_q == EN_IDLE && bresp_q == hps_pkg::RESP_SLVERR)
		else $error("service on single entry");
	a_hot_start: assert property (sup_q == SU_IDLE && rise && err_q == 10'd0 &&
		actual_temp > work_mem[hps_pkg::E_MAXSTART] |=>
		!heat_enable && alarm && error_code == hps_pkg::ERR_HOT)
		else $error("hot start not caught");
	a_lock_hold: assert property (sup_q == SU_LOCK && heat_start_bit |=>
		!heat_enable [*2] or (!heat_enable ##1 !heat_start_bit))
		else $error("reheat while locked");
	a_noarm_err: assert property (sup_q == SU_HEAT && !heat_start_bit && err_q == 10'd0 &&
		work_mem[hps_pkg::E_DIAG_EN][0] && !armed_q |=> alarm &&
		(error_code == hps_pkg::ERR_NOARM_LO || error_code == hps_pkg::ERR_NOARM_HI))
		else $error("missing no-arm error");
	a_range_fixed: assert property (prev_sel[7:0] == hps_pkg::SEL_500 |=>
		range_celsius == hps_pkg::RANGE_500)
		else $error("range select wrong");
endmodule : hps_param_store

// file: logic/hps_pkg.sv
package hps_pkg;
	localparam logic [7:0]  REG_CMD     = 8'h00;
	localparam logic [7:0]  REG_SEL     = 8'h04;
	localparam logic [7:0]  REG_DATA    = 8'h08;
	localparam logic [7:0]  REG_STAT    = 8'h0c;
	localparam logic [7:0]  REG_IDRST   = 8'h10;
	localparam logic [7:0]  SVC_SAVE    = 8'h16;
	localparam logic [7:0]  SVC_RESTORE = 8'h15;
	localparam logic [7:0]  SVC_RESET   = 8'h05;
	localparam logic [7:0]  IDRST_TYPE1 = 8'h01;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	localparam int          NUM_ENTRY   = 64;
	localparam logic [5:0]  E_SELECT    = 6'd1;
	localparam logic [5:0]  E_OK_LOW    = 6'd2;
	localparam logic [5:0]  E_OK_HIGH   = 6'd3;
	localparam logic [5:0]  E_CAL       = 6'd4;
	localparam logic [5:0]  E_LIMIT     = 6'd5;
	localparam logic [5:0]  E_MEAS      = 6'd6;
	localparam logic [5:0]  E_ORDER     = 6'd7;
	localparam logic [5:0]  E_MAXSTART  = 6'd8;
	localparam logic [5:0]  E_DIAG_EN   = 6'd9;
	localparam logic [5:0]  E_ALLOY     = 6'd10;
	localparam logic [5:0]  E_RANGE     = 6'd11;
	localparam logic [5:0]  E_DIAG_DLY  = 6'd12;
	localparam logic [5:0]  E_TIME      = 6'd31;
	localparam logic [5:0]  E_DATE      = 6'd32;
	localparam logic [5:0]  E_CNT_FIRST = 6'd35;
	localparam logic [5:0]  E_CNT_LAST  = 6'd43;
	localparam logic [5:0]  E_PROT_FIRST = 6'd50;
	localparam logic [5:0]  E_PROT_LAST  = 6'd61;
	localparam logic [15:0] DEF_SELECT   = 16'h000a;
	localparam logic [15:0] DEF_OK_LOW   = 16'h000a;
	localparam logic [15:0] DEF_OK_HIGH  = 16'h000a;
	localparam logic [15:0] DEF_CAL      = 16'h0014;
	localparam logic [15:0] DEF_LIMIT    = 16'h01f4;
	localparam logic [15:0] DEF_MEAS     = 16'h0011;
	localparam logic [15:0] DEF_MAXSTART = 16'h012c;
	localparam logic [15:0] CAL_MAX      = 16'h0028;
	localparam logic [15:0] CAL_FROM_IN  = 16'hffff;
	localparam logic [15:0] TIME_MAX     = 16'h03e7;
	localparam logic [7:0]  SEL_300      = 8'h00;
	localparam logic [7:0]  SEL_500      = 8'h04;
	localparam logic [7:0]  SEL_PC       = 8'h09;
	localparam logic [7:0]  SEL_ROTARY   = 8'h0a;
	localparam logic [7:0]  SEL_VAR      = 8'h0b;
	localparam logic [9:0]  RANGE_300    = 10'd300;
	localparam logic [9:0]  RANGE_500    = 10'd500;
	localparam logic [9:0]  ERR_HOT      = 10'd305;
	localparam logic [9:0]  ERR_LEFT_LO  = 10'd307;
	localparam logic [9:0]  ERR_LEFT_HI  = 10'd308;
	localparam logic [9:0]  ERR_NOARM_LO = 10'd309;
	localparam logic [9:0]  ERR_NOARM_HI = 10'd310;
	localparam int          CLK_MHZ      = 200;
	localparam int          TICK_MS      = 10;
	localparam int          TICK_CYC     = TICK_MS * 1000 * CLK_MHZ;
	localparam int          MEAS_UNIT_US = 100;
	localparam int          MEAS_UNIT_CYC = MEAS_UNIT_US * CLK_MHZ;
	localparam int          ST_RESERVED  = 18;
endpackage : hps_pkg

// file: testbench/hps_scanner.sv
module hps_scanner (
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{awaddr, awvalid, wdata, wvalid} = '0;
		{araddr, arvalid} = '0;
		// Response ready held high, so back-to-back calls never retoggle it
		{bready, rready} = 2'b11;
	end
	// Address and data go out together; the slave only takes them as a pair
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask : rd
endmodule : hps_scanner

// file: testbench/hps_param_store_tb.sv
module hps_param_store_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, nv_blank, heat_start_bit, measure_pulse, alarm;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        heat_enable, temp_in_window_flag;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, rotary_alloy, pc_alloy, alloy_code;
	logic [9:0]  rotary_range, pc_range, error_code, range_celsius;
	logic [15:0] actual_temp, set_point, cyc_in_raw, cyc_out_raw;
	logic [15:0] cal_temp, cyc_in_word, cyc_out_word;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	int          fail_count = 0;
	int          n_tests = 0;
	localparam logic [1:0] OK = hps_pkg::RESP_OKAY;
	localparam logic [1:0] ER = hps_pkg::RESP_SLVERR;

	hps_param_store #(.TICK_CYC(20), .MEAS_UNIT_CYC(2)) hps_param_store_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_blank,
		.heat_start_bit, .actual_temp, .set_point, .rotary_range, .rotary_alloy, .pc_range,
		.pc_alloy, .cyc_in_raw, .cyc_out_raw, .heat_enable, .measure_pulse, .alarm,
		.error_code, .temp_in_window_flag, .range_celsius, .alloy_code, .cal_temp,
		.cyc_in_word, .cyc_out_word);
	hps_scanner hps_scanner_inst (
		.aclk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
		.wdata(s_axi_wdata), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
		.bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
		.araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready),
		.rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid),
		.rready(s_axi_rready));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		hps_scanner_inst.wr(a, d, r);
		chk(32'(r), 32'(e));
	endtask : wr
	task automatic idle();
		logic [31:0] s;
		logic [1:0]  r;
		s = 32'h1000;
		for (int i = 0; i < 300 && s[12] !== 1'b0; i++) begin
			hps_scanner_inst.rd(hps_pkg::REG_STAT, s, r);
		end
	endtask : idle
	task automatic setp(input logic [5:0] n, input logic [15:0] v, input logic [1:0] e);
		wr(hps_pkg::REG_SEL, 32'(n), OK);
		wr(hps_pkg::REG_DATA, 32'(v), e);
	endtask : setp
	task automatic getp(input logic [5:0] n, input logic [15:0] v);
		logic [31:0] d;
		logic [1:0]  r;
		wr(hps_pkg::REG_SEL, 32'(n), OK);
		hps_scanner_inst.rd(hps_pkg::REG_DATA, d, r);
		chk(d, 32'(v));
	endtask : getp
	// Services always go to class entry 0, so the instance byte stays zero
	task automatic svc(input logic [7:0] c);
		wr(hps_pkg::REG_CMD, 32'(c), OK);
		idle();
	endtask : svc
	task automatic pwr(input logic b);
		aresetn <= 1'b0;
		nv_blank <= b;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		idle();
	endtask : pwr
	task automatic sel(input logic [7:0] v, input logic [9:0] rg, input logic [7:0] al);
		setp(hps_pkg::E_SELECT, 16'(v), OK);
		repeat (4) @(posedge aclk);
		chk(32'({rg, al}), 32'({range_celsius, alloy_code}));
	endtask : sel
	task automatic start(input logic v);
		heat_start_bit <= v;
		repeat (4) @(posedge aclk);
	endtask : start

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [31:0] m;
		{aresetn, heat_start_bit} = 2'b00;
		nv_blank = 1'b1;
		{actual_temp, set_point} = {16'd200, 16'd200};
		{rotary_range, rotary_alloy, pc_range, pc_alloy} = {10'd123, 8'h21, 10'd234, 8'h43};
		{cyc_in_raw, cyc_out_raw} = {16'h1234, 16'habcd};
		pwr(1'b1);
		getp(hps_pkg::E_SELECT, 16'h000a);
		getp(hps_pkg::E_LIMIT, 16'h01f4);
		getp(hps_pkg::E_CAL, 16'h0014);
		getp(hps_pkg::E_MEAS, 16'h0011);
		getp(hps_pkg::E_OK_HIGH, 16'h000a);
		svc(hps_pkg::SVC_RESET);
		setp(hps_pkg::E_MAXSTART, 16'h0064, OK);
		svc(hps_pkg::SVC_SAVE);
		setp(hps_pkg::E_MAXSTART, 16'h0050, OK);
		svc(hps_pkg::SVC_RESTORE);
		getp(hps_pkg::E_MAXSTART, 16'h0064);
		setp(hps_pkg::E_TIME, 16'h0042, OK);
		setp(hps_pkg::E_MAXSTART, 16'h0055, OK);
		pwr(1'b0);
		getp(hps_pkg::E_MAXSTART, 16'h0064);
		getp(hps_pkg::E_TIME, 16'h0042);
		svc(hps_pkg::SVC_RESET);
		getp(hps_pkg::E_MAXSTART, 16'h012c);
		svc(hps_pkg::SVC_RESTORE);
		getp(hps_pkg::E_MAXSTART, 16'h012c);
		wr(hps_pkg::REG_CMD, {16'h0, 8'h01, hps_pkg::SVC_SAVE}, ER);
		setp(hps_pkg::E_MAXSTART, 16'h0064, OK);
		wr(hps_pkg::REG_IDRST, 32'h1, OK);
		idle();
		getp(hps_pkg::E_MAXSTART, 16'h012c);
		setp(hps_pkg::E_PROT_FIRST, 16'h0001, ER);
		setp(hps_pkg::E_LIMIT, 16'h03e8, ER);
		setp(hps_pkg::E_LIMIT, hps_pkg::TIME_MAX, OK);
		hps_scanner_inst.rd(8'h20, d, r);
		chk(32'(r), 32'(ER));
		// Zero calibration is the operator's step; impulses keep running across these changes
		sel(hps_pkg::SEL_300, 10'd300, 8'h00);
		sel(hps_pkg::SEL_500, 10'd500, 8'h00);
		sel(hps_pkg::SEL_PC, 10'd234, 8'h43);
		sel(hps_pkg::SEL_ROTARY, 10'd123, 8'h21);
		setp(hps_pkg::E_RANGE, 16'd500, OK);
		setp(hps_pkg::E_ALLOY, 16'h0007, OK);
		sel(hps_pkg::SEL_VAR, 10'd500, 8'h07);
		setp(hps_pkg::E_ORDER, 16'h0001, OK);
		repeat (3) @(posedge aclk);
		chk({cyc_in_word, cyc_out_word}, 32'h3412cdab);
		setp(hps_pkg::E_CAL, 16'h0029, ER);
		setp(hps_pkg::E_CAL, hps_pkg::CAL_FROM_IN, OK);
		repeat (3) @(posedge aclk);
		chk(32'(cal_temp), 32'(set_point));
		setp(hps_pkg::E_MAXSTART, 16'h0064, OK);
		start(1'b1);
		chk({22'h0, alarm, heat_enable, error_code}, {22'h0, 2'b10, 10'd305});
		start(1'b0);
		setp(hps_pkg::E_MAXSTART, 16'h012c, OK);
		setp(hps_pkg::E_DIAG_EN, 16'h0001, OK);
		start(1'b1);
		chk({30'h0, alarm, heat_enable}, 32'h1);
		chk(32'(temp_in_window_flag), 32'h1);
		actual_temp <= 16'd250;
		repeat (4) @(posedge aclk);
		chk({22'h0, alarm, temp_in_window_flag, error_code}, {22'h0, 2'b10, 10'd308});
		start(1'b0);
		actual_temp <= 16'd100;
		start(1'b1);
		start(1'b0);
		chk({22'h0, alarm, 1'b0, error_code}, {22'h0, 2'b10, 10'd309});
		setp(hps_pkg::E_DIAG_DLY, 16'h0002, OK);
		actual_temp <= 16'd200;
		start(1'b1);
		start(1'b0);
		// In band all along, but the arming delay has not run out yet
		chk({22'h0, alarm, 1'b0, error_code}, {22'h0, 2'b10, 10'd310});
		setp(hps_pkg::E_DIAG_EN, 16'h0000, OK);
		setp(hps_pkg::E_LIMIT, 16'h0002, OK);
		start(1'b1);
		chk(32'(heat_enable), 32'h1);
		repeat (80) @(posedge aclk);
		chk(32'(heat_enable), 32'h0);
		repeat (80) @(posedge aclk);
		// Locked, so pulses run free: 17 units of 2 cycles per pair of 20-cycle ticks
		m = 32'h0;
		repeat (400) begin
			@(posedge aclk);
			m = m + 32'(measure_pulse);
		end
		chk(m, 32'd340);
		give_verdict();
	end
	// Whole run is under two thousand cycles; this leaves ample slack
	initial begin
		repeat (60000) @(posedge aclk);
		fail_count++;
		give_verdict();
	end
endmodule : hps_param_store_tb
